// ===== rtl/wdtu_pkg.sv
// constants shared by the watchdog timer unit
package wdtu_pkg;
    localparam int WDTU_CNT_W = 16;
    localparam int WDTU_DIV_SLOW = 16384;
    localparam int WDTU_DIV_FAST = 256;
    localparam logic [15:0] WDTU_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] WDTU_CNT_STEP = 16'h0001;
    // default interval, quoted against a 10 MHz reference clock
    localparam int WDTU_DEFAULT_INTERVAL_US = 6500;
    localparam int WDTU_REF_CLK_MHZ = 10;
    localparam int WDTU_DEFAULT_CYCLES = WDTU_DEFAULT_INTERVAL_US * WDTU_REF_CLK_MHZ;
    // default interval rounds up to whole ticks of the fast prescaler
    localparam int WDTU_DEFAULT_TICKS = (WDTU_DEFAULT_CYCLES + WDTU_DIV_FAST - 1) / WDTU_DIV_FAST;
    localparam logic [15:0] WDTU_DEFAULT_RELOAD = 16'(65536 - WDTU_DEFAULT_TICKS);
    localparam logic WDTU_DEFAULT_SEL_SLOW = 1'b0;
    typedef enum logic [2:0] {
        WDTU_ST_RUN = 3'b001,
        WDTU_ST_WARN = 3'b010,
        WDTU_ST_RESET = 3'b100
    } wdtu_state_e;
endpackage

// ===== rtl/wdtu_presc_if.sv
// link between the watchdog control and its clock prescaler
`timescale 1ns/1ps
`default_nettype none
interface wdtu_presc_if;
    logic run;
    logic clear;
    logic sel_slow;
    logic tick;
    modport ctrl (output run, output clear, output sel_slow, input tick);
    modport presc (input run, input clear, input sel_slow, output tick);
endinterface
`default_nettype wire

// ===== rtl/wdtu_prescaler.sv
// selectable clock prescaler that feeds the watchdog counter
`timescale 1ns/1ps
`default_nettype none
module wdtu_prescaler
    import wdtu_pkg::*;
#(
    parameter int DIV_SLOW = WDTU_DIV_SLOW,
    parameter int DIV_FAST = WDTU_DIV_FAST
) (
    input wire logic clock,
    input wire logic rst,
    wdtu_presc_if.presc pif
);
    localparam int PW = $clog2(DIV_SLOW);
    localparam logic [PW-1:0] LAST_SLOW = PW'(DIV_SLOW - 1);
    localparam logic [PW-1:0] LAST_FAST = PW'(DIV_FAST - 1);
    localparam logic [PW-1:0] ZERO = '0;
    localparam logic [PW-1:0] ONE = PW'(1);

    logic [PW-1:0] count;
    wire logic [PW-1:0] last = pif.sel_slow ? LAST_SLOW : LAST_FAST;
    wire logic at_last = (count >= last);
    wire logic [PW-1:0] next_count = (pif.clear || at_last) ? ZERO : count + ONE;

    assign pif.tick = pif.run && !pif.clear && at_last;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= ZERO;
        end else if (pif.run || pif.clear) begin
            count <= next_count;
        end
    end
endmodule // wdtu_prescaler
`default_nettype wire

// ===== rtl/wdtu_watchdog.sv
// watchdog timer unit: 16-bit reloadable up-counter with prewarning and reset request
// Notes on behaviour
// - after every reset the watchdog is enabled and counting with no software action.
// - a disable command stops counting and an enable command resumes it, except once a reset request is out.
// - on overflow a prewarning interrupt is raised first and a reset request afterwards.
// - the counter is 16 bits and advances on a tick of the system clock divided by 16384 or 256.
// - loading the counter takes the programmable reload value from its own register.
// - every service reloads the counter and clears the prescaler in the same cycle.
// - reset defaults of prescaler and reload value give 6.5 ms at a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module wdtu_watchdog
    import wdtu_pkg::*;
#(
    parameter int DIV_SLOW = WDTU_DIV_SLOW,
    parameter int DIV_FAST = WDTU_DIV_FAST
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic watchdog_service_cmd,
    input wire logic watchdog_disable_cmd,
    input wire logic watchdog_enable_cmd,
    input wire logic cfg_write,
    input wire logic [WDTU_CNT_W-1:0] cfg_reload_value,
    input wire logic cfg_sel_slow,
    output logic [WDTU_CNT_W-1:0] watchdog_count,
    output logic [WDTU_CNT_W-1:0] watchdog_reload_value,
    output logic watchdog_sel_slow,
    output logic watchdog_running,
    output logic prewarn_irq,
    output logic reset_request
);
    wdtu_presc_if pif ();
    wdtu_state_e state;
    wdtu_state_e next_state;
    logic enabled;

    wdtu_prescaler #(
        .DIV_SLOW(DIV_SLOW),
        .DIV_FAST(DIV_FAST)
    ) u_presc (
        .clock(clock),
        .rst(rst),
        .pif(pif)
    );

    // once a reset request is out the counter stops advancing (a service still reloads it) until the system resets us
    wire logic active = enabled && (state != WDTU_ST_RESET);
    wire logic overflow = active && pif.tick && (watchdog_count == WDTU_CNT_MAX);
    // disable wins over a simultaneous enable so a runaway pair cannot keep it alive
    wire logic next_enabled = watchdog_disable_cmd ? 1'b0 :
                              (watchdog_enable_cmd ? 1'b1 : enabled);
    wire logic [WDTU_CNT_W-1:0] next_count =
        (watchdog_service_cmd || overflow) ? watchdog_reload_value :
        ((active && pif.tick) ? watchdog_count + WDTU_CNT_STEP : watchdog_count);

    assign pif.run = active;
    assign pif.clear = watchdog_service_cmd;
    assign pif.sel_slow = watchdog_sel_slow;
    assign watchdog_running = active;

    // cycles since the prescaler last restarted; a config write makes it unknown until the
    // next restart, because a new select can cut the running interval short
    localparam logic [WDTU_CNT_W-1:0] GAP_SLOW = WDTU_CNT_W'(DIV_SLOW - 1);
    localparam logic [WDTU_CNT_W-1:0] GAP_FAST = WDTU_CNT_W'(DIV_FAST - 1);
    logic [WDTU_CNT_W-1:0] tick_gap;
    logic gap_valid;
    wire logic gap_restart = pif.tick || pif.clear;
    wire logic [WDTU_CNT_W-1:0] next_tick_gap =
        gap_restart ? '0 : (pif.run ? tick_gap + WDTU_CNT_STEP : tick_gap);
    wire logic next_gap_valid = gap_restart ? 1'b1 : (cfg_write ? 1'b0 : gap_valid);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_gap <= '0;
            gap_valid <= 1'b1;
        end else begin
            tick_gap <= next_tick_gap;
            gap_valid <= next_gap_valid;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            WDTU_ST_RUN: begin
                if (overflow && !watchdog_service_cmd) begin
                    next_state = WDTU_ST_WARN;
                end
            end
            WDTU_ST_WARN: begin
                if (watchdog_service_cmd) begin
                    next_state = WDTU_ST_RUN;
                end else if (overflow) begin
                    next_state = WDTU_ST_RESET;
                end
            end
            WDTU_ST_RESET: begin
                next_state = WDTU_ST_RESET;
            end
            default: begin
                next_state = WDTU_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enabled <= 1'b1;
            state <= WDTU_ST_RUN;
            watchdog_count <= WDTU_DEFAULT_RELOAD;
        end else begin
            enabled <= next_enabled;
            state <= next_state;
            watchdog_count <= next_count;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            watchdog_reload_value <= WDTU_DEFAULT_RELOAD;
            watchdog_sel_slow <= WDTU_DEFAULT_SEL_SLOW;
        end else if (cfg_write) begin
            watchdog_reload_value <= cfg_reload_value;
            watchdog_sel_slow <= cfg_sel_slow;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prewarn_irq <= 1'b0;
            reset_request <= 1'b0;
        end else begin
            prewarn_irq <= (state == WDTU_ST_RUN) && (next_state == WDTU_ST_WARN);
            reset_request <= (next_state == WDTU_ST_RESET);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_up_after_reset;
        $past(rst) |-> watchdog_running && watchdog_count == WDTU_DEFAULT_RELOAD;
    endproperty
    a_up_after_reset: assert property (p_up_after_reset)
        else $error("watchdog not running after reset");

    property p_disable_stops;
        watchdog_disable_cmd && !watchdog_service_cmd
            |=> !watchdog_running ##1 ($stable(watchdog_count) || $past(watchdog_service_cmd));
    endproperty
    a_disable_stops: assert property (p_disable_stops)
        else $error("counter moved after disable");

    property p_enable_resumes;
        watchdog_enable_cmd && !watchdog_disable_cmd && !reset_request && next_state != WDTU_ST_RESET
            |=> watchdog_running;
    endproperty
    a_enable_resumes: assert property (p_enable_resumes)
        else $error("enable did not resume counting");

    property p_warn_before_reset;
        $rose(reset_request) |-> $past(state) == WDTU_ST_WARN && !prewarn_irq;
    endproperty
    a_warn_before_reset: assert property (p_warn_before_reset)
        else $error("reset request without prior prewarning");

    property p_first_overflow_warns;
        overflow && state == WDTU_ST_RUN && !watchdog_service_cmd |=> prewarn_irq && !reset_request;
    endproperty
    a_first_overflow_warns: assert property (p_first_overflow_warns)
        else $error("first overflow did not raise prewarning");

    property p_tick_spacing;
        pif.tick |=> !pif.tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("prescaler ticks too close together");

    property p_service_reload;
        watchdog_service_cmd && !cfg_write |=> watchdog_count == $past(watchdog_reload_value) && !pif.tick;
    endproperty
    a_service_reload: assert property (p_service_reload)
        else $error("service did not reload counter");

    property p_service_clears_presc;
        watchdog_service_cmd |=> !pif.tick [*8];
    endproperty
    a_service_clears_presc: assert property (p_service_clears_presc)
        else $error("prescaler not cleared by service");

    property p_defaults;
        $past(rst) |-> watchdog_reload_value == WDTU_DEFAULT_RELOAD && watchdog_sel_slow == WDTU_DEFAULT_SEL_SLOW;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("wrong reset defaults");

    property p_count_up;
        active && pif.tick && !watchdog_service_cmd && watchdog_count != WDTU_CNT_MAX
            |=> watchdog_count == $past(watchdog_count) + WDTU_CNT_STEP;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not step up on tick");

    property p_wrap_reload;
        overflow && !watchdog_service_cmd && !cfg_write |=> watchdog_count == $past(watchdog_reload_value);
    endproperty
    a_wrap_reload: assert property (p_wrap_reload)
        else $error("counter not reloaded on wrap");

    property p_tick_period;
        pif.tick && gap_valid |-> tick_gap == (watchdog_sel_slow ? GAP_SLOW : GAP_FAST);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("prescaler tick period wrong");

    property p_prewarn_pulse;
        prewarn_irq |=> !prewarn_irq;
    endproperty
    a_prewarn_pulse: assert property (p_prewarn_pulse)
        else $error("prewarning longer than one cycle");

    property p_prewarn_state;
        prewarn_irq |-> state == WDTU_ST_WARN && !reset_request;
    endproperty
    a_prewarn_state: assert property (p_prewarn_state)
        else $error("prewarning outside the warning phase");

    property p_reset_holds;
        reset_request && !watchdog_service_cmd
            |=> reset_request && !watchdog_running && $stable(watchdog_count);
    endproperty
    a_reset_holds: assert property (p_reset_holds)
        else $error("reset request not held with counter frozen");

    property p_disable_wins;
        watchdog_disable_cmd && watchdog_enable_cmd |=> !watchdog_running;
    endproperty
    a_disable_wins: assert property (p_disable_wins)
        else $error("enable beat a simultaneous disable");
endmodule // wdtu_watchdog
`default_nettype wire

// ===== sim/wdtu_cpu_model.sv
// processor-side model that issues watchdog strobes and configuration writes
`timescale 1ns/1ps
`default_nettype none
module wdtu_cpu_model (
    input wire logic clock,
    output logic service,
    output logic dis,
    output logic ena,
    output logic cfg_write,
    output logic [15:0] cfg_reload_value,
    output logic cfg_sel_slow
);
    initial begin
        {service, dis, ena, cfg_write, cfg_sel_slow} = 5'h00;
        cfg_reload_value = 16'h0000;
    end
    // strobes last exactly one cycle, launched just after an edge
    task automatic strobe(input logic s, input logic d, input logic e, input logic w);
        @(posedge clock);
        #2;
        {service, dis, ena, cfg_write} = {s, d, e, w};
        @(posedge clock);
        #2;
        {service, dis, ena, cfg_write} = 4'h0;
    endtask
    // value and select go up together with their write strobe and then stay put
    task automatic load_cfg(input logic [15:0] r, input logic s);
        @(posedge clock);
        #2;
        cfg_reload_value = r;
        cfg_sel_slow = s;
        cfg_write = 1'b1;
        @(posedge clock);
        #2;
        cfg_write = 1'b0;
    endtask
endmodule // wdtu_cpu_model
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wdtu_pkg::*;
    localparam int DS = 32;
    localparam int DF = 16;
    localparam int DEF_TICKS = (6500 * 10 + 255) / 256;
    localparam logic [15:0] DEF_REL = 16'(65536 - DEF_TICKS);
    typedef struct packed {logic [15:0] rel; logic sel; logic [7:0] n;} wdtu_row_s;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sv, ds, en, cw, csel;
    logic [15:0] crel, cnt, rel, lastc;
    logic sel, run, irq, rreq;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    wdtu_row_s rows [4] = '{'{16'h1234, 1'b0, 8'h03}, '{16'hFFF0, 1'b0, 8'h05},
        '{16'h0000, 1'b1, 8'h02}, '{16'hABCD, 1'b1, 8'h04}};
    wdtu_cpu_model cpu (.clock(clock), .service(sv), .dis(ds), .ena(en), .cfg_write(cw),
        .cfg_reload_value(crel), .cfg_sel_slow(csel));
    wdtu_watchdog #(.DIV_SLOW(DS), .DIV_FAST(DF)) DUT (.clock(clock), .rst(rst),
        .watchdog_service_cmd(sv), .watchdog_disable_cmd(ds), .watchdog_enable_cmd(en),
        .cfg_write(cw), .cfg_reload_value(crel), .cfg_sel_slow(csel), .watchdog_count(cnt),
        .watchdog_reload_value(rel), .watchdog_sel_slow(sel), .watchdog_running(run),
        .prewarn_irq(irq), .reset_request(rreq));
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic summarize();
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk16(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic reset_check();
        rst = 1'b1;
        cyc(8);
        chk16("count", DEF_REL, cnt);
        chk16("reload", DEF_REL, rel);
        chk1("sel_slow", 1'b0, sel);
        chk1("running", 1'b1, run);
        chk1("reset_request", 1'b0, rreq);
        #1 rst = 1'b0;
        cyc(3 * DF);
        chk16("count_after_reset", DEF_REL + 16'h0003, cnt);
    endtask
    // wait for a level on a flag, bounded so a silent design cannot hang the run
    task automatic wait_for(input bit use_irq, input int lim);
        int k;
        for (k = 0; k < lim && (use_irq ? irq : rreq) !== 1'b1; k++) cyc(1);
    endtask
    initial begin
        int dv;
        reset_check();
        foreach (rows[i]) begin
            dv = rows[i].sel ? DS : DF;
            cpu.load_cfg(rows[i].rel, rows[i].sel);
            chk16("reload", rows[i].rel, rel);
            chk1("sel_slow", rows[i].sel, sel);
            cpu.strobe(1'b1, 1'b0, 1'b0, 1'b0);
            cyc(dv * rows[i].n + dv / 2 - 1);
            chk16("count", rows[i].rel + 16'(rows[i].n), cnt);
        end
        cpu.load_cfg(16'hFFFC, 1'b0);
        // services closer than one tick: prescaler must restart every time
        repeat (10) begin
            cpu.strobe(1'b1, 1'b0, 1'b0, 1'b0);
            cyc(6);
        end
        chk16("count_serviced", 16'hFFFC, cnt);
        cpu.strobe(1'b0, 1'b1, 1'b1, 1'b0);
        lastc = cnt;
        cyc(4 * DF);
        chk1("running_off", 1'b0, run);
        chk16("count_frozen", lastc, cnt);
        cpu.strobe(1'b0, 1'b0, 1'b1, 1'b0);
        chk1("running_on", 1'b1, run);
        cpu.strobe(1'b1, 1'b0, 1'b0, 1'b0);
        wait_for(1'b1, 8 * DF);
        chk1("prewarn", 1'b1, irq);
        chk1("no_reset_yet", 1'b0, rreq);
        chk16("count_wrapped", 16'hFFFC, cnt);
        cyc(1);
        chk1("prewarn_cleared", 1'b0, irq);
        cpu.strobe(1'b1, 1'b0, 1'b0, 1'b0);
        cyc(2 * DF);
        chk1("reset_after_service", 1'b0, rreq);
        wait_for(1'b1, 8 * DF);
        chk1("prewarn_again", 1'b1, irq);
        wait_for(1'b0, 8 * DF);
        chk1("reset_request", 1'b1, rreq);
        chk1("running_stopped", 1'b0, run);
        cpu.strobe(1'b0, 1'b0, 1'b1, 1'b0);
        cyc(2 * DF);
        chk1("enable_ignored", 1'b0, run);
        chk1("reset_held", 1'b1, rreq);
        reset_check();
        summarize();
    end
endmodule // tb
`default_nettype wire
